//--- rtl/math_block.sv
// four-operand arithmetic block with fault detector and ahb-lite registers
`timescale 1ns/1ps
module math_block
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic scan_tick,
    input wire logic math_en,
    input wire logic detect_en,
    input wire logic latch_wipe,
    input wire math_pkg::blk_vals_t block_values,
    output logic signed [math_pkg::VAL_W-1:0] math_result,
    output logic zero_divide_flag,
    output logic overflow_flag,
    output logic hit_output
);
    import math_pkg::*;

    logic [31:0] ctrl_q;
    logic [31:0] syms_q;
    logic [NUM_OPS-1:0][VAL_W-1:0] opnd_q;
    src_sel_t [NUM_OPS-1:0] src_q;
    det_cfg_t det_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic math_prev_q;
    logic det_prev_q;
    logic math_act_q;
    logic det_act_q;
    logic signed [INT_W-1:0] opnd_val [NUM_OPS];
    logic signed [INT_W-1:0] v [NUM_OPS];
    logic [1:0] sym [NUM_OPS-1];
    logic [1:0] grp [NUM_OPS-1];
    logic [1:0] best;
    logic signed [INT_W-1:0] r;
    logic signed [INT_W-1:0] ma;
    logic signed [INT_W-1:0] mb;
    logic zd_d;
    logic of_d;
    logic signed [VAL_W-1:0] res_d;
    logic math_run;
    logic det_run;
    logic zd_seen;
    logic of_seen;
    logic cond;
    logic addr_ok;
    logic [7:0] a8;
    logic [31:0] rd_d;

    // clamp a wide product or sum back into the working range
    function automatic logic signed [INT_W-1:0] sat
    (
        input logic signed [2*INT_W-1:0] x
    );
        if (x > SAT_LIM)
        begin
            return SAT_LIM[INT_W-1:0];
        end
        else if (x < -SAT_LIM)
        begin
            return INT_W'(-SAT_LIM);
        end
        return x[INT_W-1:0];
    endfunction

    // operand selection, clamped to the 16-bit operand range
    for (genvar g = 0; g < NUM_OPS; g++)
    begin : g_opnd
        logic signed [31:0] raw;
        assign raw = signed'(block_values[src_q[g].idx]);
        always_comb
        begin
            if (!src_q[g].ext)
            begin
                opnd_val[g] = INT_W'(signed'(opnd_q[g]));
            end
            else if (raw > 32'(VAL_MAX))
            begin
                opnd_val[g] = INT_W'(VAL_MAX);
            end
            else if (raw < 32'(signed'(VAL_MIN)))
            begin
                opnd_val[g] = INT_W'(VAL_MIN);
            end
            else
            begin
                opnd_val[g] = INT_W'(raw);
            end
        end
    end

    // equation evaluation: three passes, each reducing the strongest pair
    always_comb
    begin
        zd_d = 1'b0;
        r = '0;
        for (int i = 0; i < NUM_OPS; i++)
        begin
            v[i] = opnd_val[i];
        end
        for (int i = 0; i < NUM_OPS - 1; i++)
        begin
            sym[i] = syms_q[2*i +: 2];
            grp[i] = syms_q[SYMS_GRP + 2*i +: 2];
        end
        for (int s = 0; s < NUM_OPS - 1; s++)
        begin
            best = 2'd0;
            // strict compare keeps the leftmost of equal levels
            for (int j = 1; j < NUM_OPS - 1; j++)
            begin
                if (j < NUM_OPS - 1 - s && grp[j] > grp[best])
                begin
                    best = 2'(j);
                end
            end
            ma = v[best] < 0 ? -v[best] : v[best];
            mb = v[best+1] < 0 ? -v[best+1] : v[best+1];
            case (arith_sym_t'(sym[best]))
                SYM_ADD: r = sat((2*INT_W)'(v[best]) + (2*INT_W)'(v[best+1]));
                SYM_SUB: r = sat((2*INT_W)'(v[best]) - (2*INT_W)'(v[best+1]));
                SYM_MUL: r = sat((2*INT_W)'(v[best]) * (2*INT_W)'(v[best+1]));
                default:
                begin
                    if (v[best+1] == 0)
                    begin
                        zd_d = 1'b1;
                        r = '0;
                    end
                    else
                    begin
                        // half away from zero gives nearest integer
                        r = (ma + mb / 2) / mb;
                        if ((v[best] < 0) != (v[best+1] < 0))
                        begin
                            r = -r;
                        end
                    end
                end
            endcase
            v[best] = r;
            // close the gap: later operands and operators move down
            for (int j = 0; j < NUM_OPS - 2; j++)
            begin
                if (j >= best)
                begin
                    v[j+1] = v[j+2];
                    sym[j] = sym[j+1];
                    grp[j] = grp[j+1];
                end
            end
        end
    end

    // saturation of the final value and the error flags
    always_comb
    begin
        of_d = 1'b0;
        res_d = v[0][VAL_W-1:0];
        if (zd_d)
        begin
            res_d = VAL_MAX;
        end
        else if (v[0] > INT_W'(VAL_MAX))
        begin
            of_d = 1'b1;
            res_d = VAL_MAX;
        end
        else if (v[0] < INT_W'(VAL_MIN))
        begin
            of_d = 1'b1;
            res_d = VAL_MIN;
        end
    end

    // a block runs in a scan when enabled, counting a fresh rising edge
    assign math_run = scan_tick && math_en && (math_act_q || !math_prev_q);
    assign det_run = scan_tick && detect_en && (det_act_q || !det_prev_q);

    // enable edge tracking, sampled at scan ticks
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            math_prev_q <= 1'b0;
            det_prev_q <= 1'b0;
            math_act_q <= 1'b0;
            det_act_q <= 1'b0;
        end
        else if (scan_tick)
        begin
            math_prev_q <= math_en;
            det_prev_q <= detect_en;
            math_act_q <= math_en && (math_act_q || !math_prev_q);
            det_act_q <= detect_en && (det_act_q || !det_prev_q);
        end
    end

    // arithmetic result and flags, once per scan
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            math_result <= '0;
            zero_divide_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end
        else if (math_run)
        begin
            math_result <= res_d;
            zero_divide_flag <= zd_d;
            overflow_flag <= of_d;
        end
        else if (scan_tick && !math_en && !ctrl_q[CTRL_POLICY])
        begin
            math_result <= '0;
        end
    end

    // flags seen by the detector depend on scan order
    always_comb
    begin
        zd_seen = zero_divide_flag;
        of_seen = overflow_flag;
        if (det_q.math_first && math_run)
        begin
            zd_seen = zd_d;
            of_seen = of_d;
        end
        case (det_q.kind)
            FK_ZD: cond = zd_seen;
            FK_OF: cond = of_seen;
            FK_ANY: cond = zd_seen | of_seen;
            default: cond = 1'b0;
        endcase
    end

    // detector output: a set in the same cycle wins over a wipe
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hit_output <= 1'b0;
        end
        else if (!det_q.src_valid)
        begin
            hit_output <= 1'b0;
        end
        else if (det_run && det_q.self_clear)
        begin
            hit_output <= cond;
        end
        else if (det_run)
        begin
            hit_output <= cond | (hit_output & ~latch_wipe);
        end
        else if (latch_wipe)
        begin
            hit_output <= 1'b0;
        end
    end

    // ahb address phase capture
    assign addr_ok = hsel && htrans[1] && hready;
    assign a8 = haddr[7:0];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end
        else if (hready)
        begin
            wr_pend_q <= addr_ok && hwrite;
            wr_addr_q <= a8;
        end
    end

    // register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= CTRL_RST;
            syms_q <= SYMS_RST;
            opnd_q <= '0;
            src_q <= '0;
            det_q <= '0;
        end
        else if (wr_pend_q)
        begin
            if (wr_addr_q == ADDR_CTRL)
            begin
                ctrl_q <= {29'h0, hwdata[2:0]};
            end
            else if (wr_addr_q == ADDR_SYMS)
            begin
                syms_q <= {18'h0, hwdata[13:8], 2'h0, hwdata[5:0]};
            end
            else if (wr_addr_q == ADDR_SRC)
            begin
                src_q <= hwdata[4*NUM_OPS-1:0];
            end
            else if (wr_addr_q == ADDR_DET)
            begin
                det_q <= hwdata[4:0];
            end
            else if (wr_addr_q >= ADDR_OPND0 && wr_addr_q < ADDR_SYMS)
            begin
                opnd_q[2'((wr_addr_q - ADDR_OPND0) >> 2)] <= hwdata[15:0];
            end
        end
    end

    // read mux, registered so data stands through the data phase
    always_comb
    begin
        rd_d = 32'h0000_0000;
        if (a8 == ADDR_CTRL)
        begin
            rd_d = ctrl_q;
        end
        else if (a8 == ADDR_SYMS)
        begin
            rd_d = syms_q;
        end
        else if (a8 == ADDR_SRC)
        begin
            rd_d = {16'h0, src_q};
        end
        else if (a8 == ADDR_DET)
        begin
            rd_d = {27'h0, det_q};
        end
        else if (a8 == ADDR_STAT)
        begin
            rd_d = {11'h0, det_act_q, math_act_q, hit_output,
                    overflow_flag, zero_divide_flag, math_result};
        end
        else if (a8 >= ADDR_OPND0 && a8 < ADDR_SYMS)
        begin
            rd_d = {16'h0, opnd_q[2'((a8 - ADDR_OPND0) >> 2)]};
        end
    end

    // read data and the fixed zero-wait okay response
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_ok && !hwrite)
            begin
                hrdata <= haddr[31:8] == 24'h0 ? rd_d : 32'h0000_0000;
            end
        end
    end
endmodule

//--- rtl/math_pkg.sv
// shared constants and types for the four-operand arithmetic block
package math_pkg;
    localparam int VAL_W = 16;
    localparam int INT_W = 40;
    localparam int NUM_OPS = 4;
    localparam int NUM_BLK = 8;
    localparam logic signed [VAL_W-1:0] VAL_MAX = 16'sh7FFF;
    localparam logic signed [VAL_W-1:0] VAL_MIN = -16'sh8000;
    localparam logic signed [2*INT_W-1:0] SAT_LIM = 80'sh00000000004000000000;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OPND0 = 8'h04;
    localparam logic [7:0] ADDR_SYMS = 8'h14;
    localparam logic [7:0] ADDR_SRC = 8'h18;
    localparam logic [7:0] ADDR_DET = 8'h1C;
    localparam logic [7:0] ADDR_STAT = 8'h20;
    // field positions
    localparam int CTRL_POLICY = 0;
    localparam int CTRL_FRAC = 1;
    localparam int SYMS_GRP = 8;
    localparam int STAT_ZD = 16;
    localparam int STAT_OF = 17;
    localparam int STAT_HIT = 18;
    localparam int STAT_MACT = 19;
    localparam int STAT_DACT = 20;
    // reset values
    localparam logic [31:0] SYMS_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // operator symbols and grouping levels
    typedef enum logic [1:0] {SYM_ADD, SYM_SUB, SYM_MUL, SYM_DIV} arith_sym_t;
    typedef enum logic [1:0] {GRP_NONE, GRP_SQUARE, GRP_ROUND} grp_t;
    typedef enum logic [1:0] {FK_ZD, FK_OF, FK_ANY, FK_NONE} fault_kind_t;
    // operand source: constant or value of another block
    typedef struct packed {
        logic ext;
        logic [2:0] idx;
    } src_sel_t;
    // detector configuration word, low bits of its register
    typedef struct packed {
        logic math_first;
        logic src_valid;
        logic self_clear;
        fault_kind_t kind;
    } det_cfg_t;
    typedef logic [NUM_BLK-1:0][31:0] blk_vals_t;
endpackage

//--- testbench/math_block_props.sv
// port-level assertions for the arithmetic block
`timescale 1ns/1ps
module math_block_props
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic scan_tick,
    input wire logic math_en,
    input wire logic latch_wipe,
    input wire logic signed [math_pkg::VAL_W-1:0] math_result,
    input wire logic zero_divide_flag,
    input wire logic overflow_flag,
    input wire logic hit_output
);
    import math_pkg::*;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // a scan pulse with the block enabled, and one with it disabled
    sequence s_run;
        scan_tick && math_en;
    endsequence
    sequence s_off;
        scan_tick && !math_en;
    endsequence
    // result and flags only move on a scan pulse
    a_idle_hold: assert property (
        !scan_tick |=> $stable(math_result)
            && $stable({zero_divide_flag, overflow_flag}))
        else $error("result moved without scan");
    a_disabled_out: assert property (
        s_off |=> math_result == '0 || $stable(math_result))
        else $error("disabled result neither zero nor held");
    a_flags_hold: assert property (
        s_off |=> $stable({zero_divide_flag, overflow_flag}))
        else $error("flags moved while disabled");
    a_zd_sat: assert property (
        s_run ##1 zero_divide_flag |-> math_result == VAL_MAX
            && !overflow_flag)
        else $error("zero divide not saturated");
    a_of_sat: assert property (
        s_run ##1 overflow_flag |->
            math_result == VAL_MAX || math_result == VAL_MIN)
        else $error("overflow not saturated");
    a_wipe_clear: assert property (
        latch_wipe && !scan_tick |=> !hit_output)
        else $error("wipe did not clear hit");
    a_hit_tick: assert property (
        !scan_tick && !hit_output |=> !hit_output)
        else $error("hit rose without scan");
    a_bus_okay: assert property (
        hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule

bind math_block math_block_props i_math_block_props
(
    .hclk(hclk),
    .hresetn(hresetn),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .scan_tick(scan_tick),
    .math_en(math_en),
    .latch_wipe(latch_wipe),
    .math_result(math_result),
    .zero_divide_flag(zero_divide_flag),
    .overflow_flag(overflow_flag),
    .hit_output(hit_output)
);

//--- testbench/block_source.sv
// model of the other function blocks that supply operand values
`timescale 1ns/1ps
module block_source
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ld,
    input wire logic [2:0] sel,
    input wire logic [31:0] val,
    output math_pkg::blk_vals_t vals
);
    import math_pkg::*;
    // actual values may lie far outside the operand range
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            vals <= '0;
        else if (ld)
            vals[sel] <= val;
    end
endmodule

//--- testbench/math_block_tb_top.sv
// self-checking bench for the four-operand arithmetic block
`timescale 1ns/1ps
module math_block_tb_top;
    import math_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic scan_tick = 1'b0;
    logic math_en = 1'b1;
    logic detect_en = 1'b1;
    logic latch_wipe = 1'b0;
    logic ld = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [31:0] val = 32'h0000_0000;
    blk_vals_t vals;
    logic signed [VAL_W-1:0] math_result;
    logic zero_divide_flag;
    logic overflow_flag;
    logic hit_output;
    logic [31:0] q;
    int bad_count = 0;
    int n_compared = 0;

    // 100 MHz clock
    always #5 hclk = ~hclk;

    math_block i_math_block (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .scan_tick(scan_tick),
        .math_en(math_en), .detect_en(detect_en), .latch_wipe(latch_wipe),
        .block_values(vals), .math_result(math_result),
        .zero_divide_flag(zero_divide_flag), .overflow_flag(overflow_flag),
        .hit_output(hit_output));
    block_source i_block_source (.hclk(hclk), .hresetn(hresetn), .ld(ld),
        .sel(sel), .val(val), .vals(vals));

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            bad_count++;
        end
    endtask

    // wait for hready at a rising edge, bounded
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                bad_count++;
                final_report();
            end
            @(posedge hclk);
        end
    endtask

    // one single-word transfer; read data lands in q
    task automatic ahb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic tick;
        scan_tick <= 1'b1;
        @(posedge hclk);
        scan_tick <= 1'b0;
        // a quiet edge passes, so outputs have settled when judged
        @(posedge hclk);
    endtask

    task automatic wipe;
        latch_wipe <= 1'b1;
        @(posedge hclk);
        latch_wipe <= 1'b0;
        @(posedge hclk);
    endtask

    task automatic setb(input logic [2:0] s, input logic [31:0] v);
        ld <= 1'b1;
        sel <= s;
        val <= v;
        @(posedge hclk);
        ld <= 1'b0;
        @(posedge hclk);
    endtask

    task automatic chk_hit(input logic e);
        chk({31'h0, hit_output}, {31'h0, e});
    endtask

    // load operands and symbols, run one scan, judge result and flags
    task automatic run_eq(input logic [15:0] a, b, c, d,
            input logic [31:0] syms, input logic [15:0] res,
            input logic [1:0] fl);
        ahb(1'b1, ADDR_OPND0, {16'h0000, a});
        ahb(1'b1, ADDR_OPND0 + 8'h04, {16'h0000, b});
        ahb(1'b1, ADDR_OPND0 + 8'h08, {16'h0000, c});
        ahb(1'b1, ADDR_OPND0 + 8'h0C, {16'h0000, d});
        ahb(1'b1, ADDR_SYMS, syms);
        tick();
        chk({16'h0000, math_result}, {16'h0000, res});
        chk({30'h0, zero_divide_flag, overflow_flag}, {30'h0, fl});
    endtask

    task automatic zd_run;
        run_eq(16'h0005, 16'h0000, 16'h0001, 16'h0000, 32'h0B, 16'h7FFF,
            2'b10);
    endtask

    task automatic ok_run;
        run_eq(16'h0001, 16'h0001, 16'h0001, 16'h0001, 32'h2A, 16'h0001,
            2'b00);
    endtask

    task automatic t_regs;
        ahb(1'b0, ADDR_CTRL, '0);
        chk(q, CTRL_RST);
        ahb(1'b0, ADDR_SYMS, '0);
        chk(q, SYMS_RST);
        ahb(1'b0, 8'h40, '0);
        chk(q, 32'h0000_0000);
        ahb(1'b1, ADDR_CTRL, 32'h0000_0006);
        ahb(1'b0, ADDR_CTRL, '0);
        chk(q, 32'h0000_0006);
    endtask

    task automatic t_math;
        run_eq(16'd12, 16'd6, 16'd3, 16'd1, 32'h91C, 16'd13, 2'b00);
        run_eq(16'd2, 16'd3, 16'd1, 16'd4, 32'h2408, 16'd17, 2'b00);
        run_eq(16'd100, 16'd25, 16'd2, 16'd1, 32'h120D, 16'd25, 2'b00);
        run_eq(16'd20, 16'd5, 16'd3, 16'd2, 32'h15, 16'd10, 2'b00);
        run_eq(16'd7, 16'd2, 16'd1, 16'd0, 32'h0B, 16'd4, 2'b00);
        zd_run();
        ahb(1'b0, ADDR_STAT, '0);
        chk(q, 32'h0019_7FFF);
        run_eq(16'h7FFF, 16'd1, 16'd0, 16'd0, 32'h0, 16'h7FFF, 2'b01);
        run_eq(16'h8000, 16'd1, 16'd1, 16'd0, 32'h09, 16'h8000, 2'b01);
        ok_run();
    endtask

    task automatic t_blocks;
        setb(3'h0, 32'h0001_86A0);
        setb(3'h5, 32'hFFFE_7960);
        ahb(1'b1, ADDR_SRC, 32'h0000_0008);
        run_eq(16'h0, 16'h0, 16'h0, 16'h0, 32'h0, 16'h7FFF, 2'b00);
        ahb(1'b1, ADDR_SRC, 32'h0000_000D);
        run_eq(16'h0, 16'h0, 16'h0, 16'h0, 32'h0, 16'h8000, 2'b00);
        setb(3'h5, 32'hFFFF_FFFB);
        tick();
        chk({16'h0000, math_result}, 32'h0000_FFFB);
    endtask

    task automatic t_disable;
        math_en <= 1'b0;
        tick();
        chk({16'h0000, math_result}, 32'h0000_0000);
        ahb(1'b1, ADDR_CTRL, 32'h0000_0001);
        math_en <= 1'b1;
        tick();
        chk({16'h0000, math_result}, 32'h0000_FFFB);
        math_en <= 1'b0;
        tick();
        chk({16'h0000, math_result}, 32'h0000_FFFB);
        math_en <= 1'b1;
        ahb(1'b1, ADDR_SRC, 32'h0000_0000);
    endtask

    task automatic t_detect;
        for (int k = 0; k < 4; k++)
        begin
            ahb(1'b1, ADDR_DET, {27'h0, 3'h7, k[1:0]});
            zd_run();
            chk_hit(!k[0]);
        end
        ahb(1'b1, ADDR_DET, 32'h0000_001C);
        zd_run();
        chk_hit(1'b1);
        ok_run();
        chk_hit(1'b0);
        ahb(1'b1, ADDR_DET, 32'h0000_0018);
        zd_run();
        chk_hit(1'b1);
        ok_run();
        chk_hit(1'b1);
        wipe();
        chk_hit(1'b0);
        ahb(1'b1, ADDR_DET, 32'h0000_0014);
        zd_run();
        chk_hit(1'b0);
        ahb(1'b1, ADDR_DET, 32'h0000_000C);
        ok_run();
        ok_run();
        chk_hit(1'b0);
        zd_run();
        chk_hit(1'b0);
        tick();
        chk_hit(1'b1);
        detect_en <= 1'b0;
        wipe();
        tick();
        chk_hit(1'b0);
        detect_en <= 1'b1;
        tick();
        chk_hit(1'b1);
    endtask

    // reset for two cycles, then the scenarios
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_math();
        t_blocks();
        t_disable();
        t_detect();
        final_report();
    end
endmodule
